/* File: shared/din_selftest_pkg.sv */
// shared constants and carriers for the discrete input reset and self-test control
package din_selftest_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CFG_W = 9;
  localparam int unsigned SELFTEST_BIT = 8;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned POR_DELAY_US = 200;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int unsigned SAG_US = 9;
  localparam int unsigned SAG_CYC = SAG_US * CLK_MHZ;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  localparam logic [NUM_CH-1:0] SAMPLE_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // per-channel front end controls
  typedef struct packed {
    logic [NUM_CH-1:0] pull_up_en;
    logic [NUM_CH-1:0] pull_down_en;
    logic [NUM_CH-1:0] stim_en;
    logic [NUM_CH-1:0] stim_val;
  } front_end_ctrl_t;

  // raw serial pins, asynchronous at the port and also held in the synchroniser stages
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sel_data;
    logic serial_in;
  } spi_pins_t;
endpackage : din_selftest_pkg

/* File: hw/por_sequencer.sv */
// power-on reset delay and supply sag detector
module por_sequencer
  import din_selftest_pkg::*;
#(
  parameter int unsigned DELAY_CYC = POR_DELAY_CYC,
  parameter int unsigned SAG_CYCLES = SAG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // supply monitor level, high while logic supply is below the sag threshold
  input wire logic supply_low,
  // active while the internal reset is held
  output logic por_active
);
  import din_selftest_pkg::*;

  typedef struct packed {
    logic [1:0] low_sync;
    logic [31:0] delay_cnt;
    logic [31:0] sag_cnt;
    logic active;
  } por_state_t;

  por_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.low_sync = {s_q.low_sync[0], supply_low};
    if (s_q.low_sync[1]) begin
      // only a sustained sag rearms the reset; short dips are ridden through
      if (s_q.sag_cnt < SAG_CYCLES - 1) begin
        s_d.sag_cnt = s_q.sag_cnt + 32'h1;
      end else begin
        s_d.active = 1'b1;
        s_d.delay_cnt = 32'h0;
      end
    end else begin
      s_d.sag_cnt = 32'h0;
      if (s_q.active) begin
        if (s_q.delay_cnt < DELAY_CYC - 1) begin
          s_d.delay_cnt = s_q.delay_cnt + 32'h1;
        end else begin
          s_d.active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{low_sync: SYNC_RESET, delay_cnt: 32'h0, sag_cnt: 32'h0, active: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign por_active = s_q.active;

  chk_por_holds: assert property (@(posedge clk) disable iff (reset)
    $fell(s_q.active) |-> $past(s_q.delay_cnt) == DELAY_CYC - 1)
    else $error("reset released before delay expired");
  chk_sag_rearm: assert property (@(posedge clk) disable iff (reset)
    $rose(s_q.active) |-> $past(s_q.low_sync[1]))
    else $error("reset rearmed without supply sag");
endmodule : por_sequencer

/* File: hw/din_selftest_ctrl.sv */
// serial configuration, sampling, power-up high impedance and self-test control
// Functional notes
// - at power-on every front end is high impedance, no pull-up or pull-down
// - high impedance until first configuration latch, then pulls follow config bits
// - internal reset lasts about 200us; configuration writes ignored meanwhile
// - supply sag reasserts reset, clears config and sample, front ends high impedance
// - configuration bit 8 set selects self-test, clear selects normal operation
// - in self-test each config bit drives its channel comparator stimulus
// - in self-test all pull-up and pull-down switches are off
// - nine-bit config shift register shifts serial in at low bit on clock rise
// - chip select rise with config selected copies shift register into config latch
// - latched zero gives supply/open with pull-down, one gives ground/open with pull-up
// - chip select fall with data selected loads eight comparator outputs into sample
module din_selftest_ctrl
  import din_selftest_pkg::*;
#(
  parameter int unsigned DELAY_CYC = POR_DELAY_CYC,
  parameter int unsigned SAG_CYCLES = SAG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // supply monitor
  input wire logic supply_low,
  // serial link pins, asynchronous to clk
  input wire din_selftest_pkg::spi_pins_t pins,
  output logic serial_out,
  output logic serial_out_oe,
  // comparator results from the analog front ends
  input wire logic [NUM_CH-1:0] comparator_out,
  // front end controls
  output din_selftest_pkg::front_end_ctrl_t input_front_end,
  // status
  output logic configured,
  output logic selftest_active
);
  import din_selftest_pkg::*;

  typedef struct packed {
    spi_pins_t sync1;
    spi_pins_t sync2;
    spi_pins_t prev;
    logic [CFG_W-1:0] config_shift_reg;
    logic [CFG_W-1:0] config_latch;
    logic [NUM_CH-1:0] input_sample_reg;
    logic [NUM_CH-1:0] cmp_sync1;
    logic [NUM_CH-1:0] cmp_sync2;
    logic configured;
    logic sout;
    logic sout_oe;
    front_end_ctrl_t fe;
  } ctrl_state_t;

  // edge history starts at the idle pin levels: chip select high, clock low,
  // so the first cycle after reset cannot see a false chip select rise
  localparam spi_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, sel_data: 1'b0, serial_in: 1'b0};
  localparam ctrl_state_t CTRL_RESET = '{sync1: PINS_IDLE, sync2: PINS_IDLE, prev: PINS_IDLE, default: '0};

  ctrl_state_t s_q, s_d;
  logic por_active;

  // reset delay and sag filter; supply_low is synchronised inside
  por_sequencer #(
    .DELAY_CYC(DELAY_CYC),
    .SAG_CYCLES(SAG_CYCLES)
  ) u_por (
    .clk(clk),
    .reset(reset),
    .supply_low(supply_low),
    .por_active(por_active)
  );

  // front end drive from the latched configuration only
  function automatic front_end_ctrl_t fe_drive(input logic [CFG_W-1:0] cl, input logic cfg_done);
    front_end_ctrl_t f;
    logic test;
    test = cl[SELFTEST_BIT];
    f.stim_en = test ? {NUM_CH{1'b1}} : {NUM_CH{1'b0}};
    f.stim_val = test ? cl[NUM_CH-1:0] : {NUM_CH{1'b0}};
    if (!cfg_done || test) begin
      f.pull_up_en = {NUM_CH{1'b0}};
      f.pull_down_en = {NUM_CH{1'b0}};
    end else begin
      f.pull_up_en = cl[NUM_CH-1:0];
      f.pull_down_en = ~cl[NUM_CH-1:0];
    end
    return f;
  endfunction : fe_drive

  // edges are found on the synchronised copy against the one before it
  function automatic logic rise_of(input logic cur, input logic old);
    return cur & ~old;
  endfunction : rise_of

  logic sclk_rise, cs_rise, cs_fall;
  assign sclk_rise = rise_of(s_q.sync2.sclk, s_q.prev.sclk);
  assign cs_rise = rise_of(s_q.sync2.cs_n, s_q.prev.cs_n);
  assign cs_fall = rise_of(s_q.prev.cs_n, s_q.sync2.cs_n);

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.cmp_sync1 = comparator_out;
    s_d.cmp_sync2 = s_q.cmp_sync1;
    if (por_active) begin
      // hold config, sample and configured flag cleared; writes during the delay are dropped
      s_d.config_shift_reg = CFG_RESET;
      s_d.config_latch = CFG_RESET;
      s_d.input_sample_reg = SAMPLE_RESET;
      s_d.configured = 1'b0;
    end else if (!s_q.sync2.cs_n) begin
      // an sclk rise in the load cycle is lost; the host keeps sclk low around the cs fall
      if (cs_fall && s_q.sync2.sel_data) begin
        s_d.input_sample_reg = s_q.cmp_sync2;
      end else if (sclk_rise) begin
        // the sample register takes serial_in as well, so devices can be chained
        if (s_q.sync2.sel_data) begin
          s_d.input_sample_reg = {s_q.input_sample_reg[NUM_CH-2:0], s_q.sync2.serial_in};
        end else begin
          s_d.config_shift_reg = {s_q.config_shift_reg[CFG_W-2:0], s_q.sync2.serial_in};
        end
      end
    end else if (cs_rise && !s_q.sync2.sel_data) begin
      // only the chip select rise copies, so a half-shifted self-test bit never acts
      s_d.config_latch = s_q.config_shift_reg;
      s_d.configured = 1'b1;
    end
    // output shows msb of the selected register; three cycles of lag versus the pin clock
    s_d.sout_oe = ~s_q.sync2.cs_n;
    s_d.sout = s_q.sync2.sel_data ? s_d.input_sample_reg[NUM_CH-1] : s_d.config_shift_reg[CFG_W-1];
    s_d.fe = fe_drive(s_d.config_latch, s_d.configured);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_out = s_q.sout;
  assign serial_out_oe = s_q.sout_oe;
  assign input_front_end = s_q.fe;
  assign configured = s_q.configured;
  assign selftest_active = s_q.fe.stim_en[0];

  // checks on the registered state, all sampled on clk
  chk_hiz_unconfig: assert property (@(posedge clk) disable iff (reset)
    !s_q.configured |-> (s_q.fe.pull_up_en == '0 && s_q.fe.pull_down_en == '0))
    else $error("pulls enabled before configuration");
  chk_por_clears: assert property (@(posedge clk) disable iff (reset)
    $past(por_active) |-> (s_q.config_latch == CFG_RESET && s_q.input_sample_reg == SAMPLE_RESET))
    else $error("registers not cleared under reset");
  chk_test_pulls_off: assert property (@(posedge clk) disable iff (reset)
    s_q.config_latch[SELFTEST_BIT] |-> (s_q.fe.pull_up_en == '0 && s_q.fe.pull_down_en == '0))
    else $error("pulls on in self-test");
  chk_test_stimulus: assert property (@(posedge clk) disable iff (reset)
    s_q.config_latch[SELFTEST_BIT] |-> s_q.fe.stim_val == s_q.config_latch[NUM_CH-1:0])
    else $error("stimulus does not follow config");
  chk_latch_copy: assert property (@(posedge clk) disable iff (reset)
    (cs_rise && !s_q.sync2.sel_data && !por_active) |=> s_q.config_latch == $past(s_q.config_shift_reg))
    else $error("latch missed shift register");
  chk_pull_map: assert property (@(posedge clk) disable iff (reset)
    (s_q.configured && !s_q.config_latch[SELFTEST_BIT]) |->
      (s_q.fe.pull_up_en == s_q.config_latch[NUM_CH-1:0] && s_q.fe.pull_down_en == ~s_q.config_latch[NUM_CH-1:0]))
    else $error("pull mapping wrong");
  chk_sample_load: assert property (@(posedge clk) disable iff (reset)
    (cs_fall && s_q.sync2.sel_data && !por_active) |=> s_q.input_sample_reg == $past(s_q.cmp_sync2))
    else $error("sample not loaded");
  chk_shift_in: assert property (@(posedge clk) disable iff (reset)
    (sclk_rise && !s_q.sync2.cs_n && !s_q.sync2.sel_data && !cs_fall && !por_active) |=>
      s_q.config_shift_reg[0] == $past(s_q.sync2.serial_in))
    else $error("shift register did not take serial in");
  chk_no_early_test: assert property (@(posedge clk) disable iff (reset)
    $rose(s_q.fe.stim_en[0]) |-> $past(cs_rise))
    else $error("self-test started without latch");

  // quiet periods: registers hold unless their own event or the internal reset comes; the synchroniser stages step every cycle
  chk_hiz_por: assert property (@(posedge clk) disable iff (reset)
    por_active |=> (s_q.fe.pull_up_en == '0 && s_q.fe.pull_down_en == '0))
    else $error("pulls enabled during internal reset");
  chk_shift_refused: assert property (@(posedge clk) disable iff (reset)
    por_active |=> s_q.config_shift_reg == CFG_RESET)
    else $error("shift register took data during internal reset");
  chk_normal_quiet: assert property (@(posedge clk) disable iff (reset)
    !s_q.config_latch[SELFTEST_BIT] |-> (s_q.fe.stim_en == '0 && s_q.fe.stim_val == '0))
    else $error("stimulus active in normal mode");
  chk_test_enable: assert property (@(posedge clk) disable iff (reset)
    s_q.config_latch[SELFTEST_BIT] |-> s_q.fe.stim_en == {NUM_CH{1'b1}})
    else $error("stimulus not enabled in self-test");
  chk_latch_steady: assert property (@(posedge clk) disable iff (reset)
    (!cs_rise && !por_active) |=> $stable(s_q.config_latch))
    else $error("latch changed without chip select rise");
  chk_fe_steady: assert property (@(posedge clk) disable iff (reset)
    (!cs_rise && !por_active) |=> $stable(s_q.fe))
    else $error("front end changed without latch");
  chk_cfg_set: assert property (@(posedge clk) disable iff (reset)
    (cs_rise && !s_q.sync2.sel_data && !por_active) |=> s_q.configured)
    else $error("configured flag not set by latch");
  chk_cfg_cleared: assert property (@(posedge clk) disable iff (reset)
    $fell(s_q.configured) |-> $past(por_active))
    else $error("configured flag cleared without reset");
  chk_shift_idle: assert property (@(posedge clk) disable iff (reset)
    (s_q.sync2.cs_n && !por_active) |=> $stable(s_q.config_shift_reg))
    else $error("shift register moved while deselected");
  chk_sample_idle: assert property (@(posedge clk) disable iff (reset)
    (s_q.sync2.cs_n && !por_active) |=> $stable(s_q.input_sample_reg))
    else $error("sample register moved while deselected");
  chk_sample_shift: assert property (@(posedge clk) disable iff (reset)
    (sclk_rise && !s_q.sync2.cs_n && s_q.sync2.sel_data && !cs_fall && !por_active) |=>
      s_q.input_sample_reg[0] == $past(s_q.sync2.serial_in))
    else $error("sample register did not take serial in");
  chk_oe_follows_cs: assert property (@(posedge clk) disable iff (reset)
    s_q.sout_oe == !$past(s_q.sync2.cs_n))
    else $error("output enable does not follow chip select");
  chk_pin_sync: assert property (@(posedge clk) disable iff (reset)
    s_q.sync2 == $past(s_q.sync1))
    else $error("pin synchroniser skipped a stage");
  chk_cmp_sync: assert property (@(posedge clk) disable iff (reset)
    s_q.cmp_sync2 == $past(s_q.cmp_sync1))
    else $error("comparator synchroniser skipped a stage");
endmodule : din_selftest_ctrl

/* File: test/spi_host_model.sv */
// serial host model that writes configuration and reads samples
module spi_host_model (
  // clock
  input wire logic clk,
  // serial link
  output din_selftest_pkg::spi_pins_t pins,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import din_selftest_pkg::*;

  // idle: deselected, clock low
  initial pins = 4'h4;

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // one frame of n bits, msb first; chip select stays low until close
  task automatic frame(input logic sel, input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    pins.sel_data = sel;
    tick(2);
    pins.cs_n = 1'b0;
    tick(8);
    for (int i = n - 1; i >= 0; i--) begin
      pins.serial_in = tx[i];
      rx[i] = serial_out;
      tick(8);
      pins.sclk = 1'b1;
      tick(8);
      pins.sclk = 1'b0;
    end
    // a released data line must not look like it still holds its last bit
    pins.serial_in = ~pins.serial_in;
  endtask : frame

  task automatic close();
    pins.cs_n = 1'b1;
    tick(8);
  endtask : close
endmodule : spi_host_model

/* File: test/test_discrete_input_por_selftest_ctrl.sv */
// self-checking bench for the discrete input reset and self-test control
module test_discrete_input_por_selftest_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import din_selftest_pkg::*;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic supply_low = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] comp;
  logic [8:0] rx;
  spi_pins_t pins;
  front_end_ctrl_t fe;
  logic serial_out;
  logic serial_out_oe;
  logic configured;
  logic selftest_active;
  int num_errors = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  // analog comparator: stimulus replaces the external level while enabled
  assign comp = (fe.stim_en & fe.stim_val) | (~fe.stim_en & ext);

  din_selftest_ctrl #(.DELAY_CYC(50)) dut (
    .clk(clk),
    .reset(reset),
    .supply_low(supply_low),
    .pins(pins),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .comparator_out(comp),
    .input_front_end(fe),
    .configured(configured),
    .selftest_active(selftest_active)
  );

  spi_host_model host (
    .clk(clk),
    .pins(pins),
    .serial_out(serial_out)
  );

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic want(input logic [7:0] up, input logic [7:0] dn, input logic [7:0] se,
                      input logic [7:0] sv, input logic cf, input logic st);
    check({fe, configured, selftest_active}, {up, dn, se, sv, cf, st});
  endtask : want

  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    // one shifted bit and a latch while the internal reset still holds
    host.frame(1'b0, 9'h1ff, 1, rx);
    host.close();
    host.tick(80);
    want(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    host.frame(1'b0, 9'h0a5, 9, rx);
    check({25'h0, rx}, 34'h000);
    host.close();
    want(8'ha5, 8'h5a, 8'h00, 8'h00, 1'b1, 1'b0);
    ext = 8'h3c;
    host.tick(4);
    host.frame(1'b1, 9'h000, 8, rx);
    host.close();
    check({25'h0, rx}, 34'h03c);
    host.frame(1'b0, 9'h1c3, 9, rx);
    want(8'ha5, 8'h5a, 8'h00, 8'h00, 1'b1, 1'b0);
    check({25'h0, rx}, 34'h0a5);
    check({33'h0, serial_out_oe}, 34'h1);
    host.close();
    check({33'h0, serial_out_oe}, 34'h0);
    want(8'h00, 8'h00, 8'hff, 8'hc3, 1'b1, 1'b1);
    host.frame(1'b1, 9'h000, 8, rx);
    host.close();
    check({25'h0, rx}, 34'h0c3);
    host.frame(1'b0, 9'h000, 9, rx);
    host.close();
    want(8'h00, 8'hff, 8'h00, 8'h00, 1'b1, 1'b0);
    // supply sag long enough to re-arm the internal reset
    supply_low = 1'b1;
    host.tick(int'(SAG_CYC) + 12);
    supply_low = 1'b0;
    host.tick(70);
    want(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    end_of_test();
  end

  // frames take under 200 cycles and the whole test about 1900; this leaves ample margin
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule : test_discrete_input_por_selftest_ctrl
